/* rtl/hires_pwm_timebase_duty.sv */
// PWM time base, special event trigger and duty control, AXI4-Lite slave.
// Assumes one clock aclk; fault and current-limit inputs are asynchronous pins.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`include "pwm_defines.svh"
module hires_pwm_timebase_duty
  import pwm_pkg::*;
#(
  parameter int NUM_GEN = 4,
  parameter int DEAD_CYCLES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_GEN-1:0] fault_in,
  input wire logic [NUM_GEN-1:0] current_limit_in,
  output logic [NUM_GEN-1:0] high_side_output,
  output logic [NUM_GEN-1:0] low_side_output,
  output logic [NUM_GEN-1:0] controller_irq_flag,
  output logic special_event_trigger
);
  logic module_on;
  logic [3:0] special_event_postscale;
  logic [2:0] input_clock_divide;
  logic [15:0] master_period;
  logic [15:0] special_event_compare_value;
  logic [15:0] shared_duty_value;
  logic [15:0] master_time_base_counter;
  logic [15:0] generator_control [NUM_GEN];
  logic [15:0] primary_duty_value [NUM_GEN];
  logic [15:0] secondary_duty_value [NUM_GEN];
  logic [15:0] primary_phase_value [NUM_GEN];
  logic [1:0] output_pair_mode [NUM_GEN];
  logic [NUM_GEN-1:0] fault_irq_pending;
  logic [NUM_GEN-1:0] current_limit_irq_pending;
  logic [NUM_GEN-1:0] trigger_irq_pending;

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge[7:0] = strb[0] ? d[7:0] : old[7:0];
    merge[15:8] = strb[1] ? d[15:8] : old[15:8];
  endfunction : merge

  // Generator index of an address, NUM_GEN when outside the generator registers
  function automatic int gen_of(input logic [11:0] a);
    int g;
    g = (int'(a) - int'(`OFS_GEN_BASE)) >>> 5;
    if (a < `OFS_GEN_BASE || g >= NUM_GEN || a[4:2] > `GOFS_MODE)
      gen_of = NUM_GEN;
    else
      gen_of = g;
  endfunction : gen_of

  function automatic logic top_hit(input logic [11:0] a);
    top_hit = (a[11:2] <= `OFS_MCOUNT >> 2);
  endfunction : top_hit

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (top_hit(aw_addr_r) || gen_of(aw_addr_r) < NUM_GEN) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Top registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_on <= 1'b0;
      special_event_postscale <= 4'h0;
      input_clock_divide <= 3'h0;
      master_period <= `PERIOD_RST;
      special_event_compare_value <= 16'h0000;
      shared_duty_value <= 16'h0000;
    end else if (do_write) begin
      case (aw_addr_r)
        `OFS_TB_CTRL: begin
          module_on <= w_strb_r[1] ? w_data_r[`TB_ON_BIT] : module_on;
          if (!module_on && w_strb_r[0])
            special_event_postscale <= w_data_r[3:0];
        end
        `OFS_CLK_DIV:
          if (!module_on && w_strb_r[0])
            input_clock_divide <= w_data_r[2:0];
        `OFS_PERIOD: master_period <= merge(master_period, w_data_r, w_strb_r);
        `OFS_SEVT:
          special_event_compare_value <= merge(special_event_compare_value, w_data_r,
                                               w_strb_r) & `SEVT_MASK;
        `OFS_SDUTY: shared_duty_value <= merge(shared_duty_value, w_data_r, w_strb_r);
        default: ;
      endcase
    end
  end

  // ****************************************
  // Generator registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        generator_control[g] <= 16'h0000;
        primary_duty_value[g] <= 16'h0000;
        secondary_duty_value[g] <= 16'h0000;
        primary_phase_value[g] <= 16'h0000;
        output_pair_mode[g] <= 2'h0;
      end
    end else if (do_write && gen_of(aw_addr_r) < NUM_GEN) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        if (gen_of(aw_addr_r) == g) begin
          case (aw_addr_r[4:2])
            `GOFS_CTRL:
              generator_control[g] <= module_on ?
                ((merge(generator_control[g], w_data_r, w_strb_r) & `CTL_WR_MASK &
                  ~`CTL_CFG_MASK) | (generator_control[g] & `CTL_CFG_MASK)) :
                (merge(generator_control[g], w_data_r, w_strb_r) & `CTL_WR_MASK);
            `GOFS_PDUTY:
              primary_duty_value[g] <= merge(primary_duty_value[g], w_data_r, w_strb_r);
            `GOFS_SDUTY:
              secondary_duty_value[g] <= merge(secondary_duty_value[g], w_data_r, w_strb_r);
            `GOFS_PHASE:
              primary_phase_value[g] <= merge(primary_phase_value[g], w_data_r, w_strb_r);
            `GOFS_MODE:
              if (!module_on && w_strb_r[0])
                output_pair_mode[g] <= w_data_r[1:0];
            default: ;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] rd_val;
  always_comb begin
    int g;
    g = gen_of(s_axi_araddr);
    rd_val = 16'h0000;
    case (s_axi_araddr)
      `OFS_TB_CTRL: rd_val = {module_on, 11'h000, special_event_postscale};
      `OFS_CLK_DIV: rd_val = {13'h0000, input_clock_divide};
      `OFS_PERIOD: rd_val = master_period;
      `OFS_SEVT: rd_val = special_event_compare_value;
      `OFS_SDUTY: rd_val = shared_duty_value;
      `OFS_MCOUNT: rd_val = master_time_base_counter;
      default:
        if (g < NUM_GEN) begin
          case (s_axi_araddr[4:2])
            `GOFS_CTRL:
              rd_val = {fault_irq_pending[g], current_limit_irq_pending[g],
                        trigger_irq_pending[g], generator_control[g][12:0]};
            `GOFS_PDUTY: rd_val = primary_duty_value[g];
            `GOFS_SDUTY: rd_val = secondary_duty_value[g];
            `GOFS_PHASE: rd_val = primary_phase_value[g];
            `GOFS_MODE: rd_val = {14'h0000, output_pair_mode[g]};
            default: rd_val = 16'h0000;
          endcase
        end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= (top_hit(s_axi_araddr) || gen_of(s_axi_araddr) < NUM_GEN) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Input clock divider and master time base
  // ****************************************
  logic [5:0] div_cnt_r;
  logic [5:0] div_last;
  logic tick;
  assign div_last = 6'((7'h01 << ((input_clock_divide > `DIV_MAX_CODE) ?
                                  `DIV_MAX_CODE : input_clock_divide)) - 7'h01);
  assign tick = module_on && div_cnt_r == div_last;

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on || tick)
      div_cnt_r <= 6'h00;
    else
      div_cnt_r <= div_cnt_r + 6'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on)
      master_time_base_counter <= 16'h0000;
    else if (tick)
      master_time_base_counter <= (master_time_base_counter >= master_period - 16'h0001) ?
                                  16'h0000 : master_time_base_counter + 16'h0001;
  end

  // ****************************************
  // Special event postscaler
  // ****************************************
  logic [3:0] post_cnt_r;
  logic sevt_match;
  assign sevt_match = tick && master_time_base_counter == special_event_compare_value;

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on) begin
      post_cnt_r <= 4'h0;
      special_event_trigger <= 1'b0;
    end else begin
      special_event_trigger <= sevt_match && post_cnt_r == special_event_postscale;
      if (sevt_match)
        post_cnt_r <= (post_cnt_r == special_event_postscale) ? 4'h0 : post_cnt_r + 4'h1;
    end
  end

  // ****************************************
  // Pin synchronisers and per-generator logic
  // ****************************************
  logic [NUM_GEN-1:0] flt_s1_r, flt_s2_r, flt_s3_r;
  logic [NUM_GEN-1:0] cl_s1_r, cl_s2_r, cl_s3_r;
  logic [NUM_GEN-1:0] gen_h;
  logic [NUM_GEN-1:0] gen_l;
  logic [NUM_GEN-1:0] gen_end;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {flt_s1_r, flt_s2_r, flt_s3_r} <= '0;
      {cl_s1_r, cl_s2_r, cl_s3_r} <= '0;
    end else begin
      flt_s1_r <= fault_in;
      flt_s2_r <= flt_s1_r;
      flt_s3_r <= flt_s2_r;
      cl_s1_r <= current_limit_in;
      cl_s2_r <= cl_s1_r;
      cl_s3_r <= cl_s2_r;
    end
  end

  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_ch
    logic [15:0] ctl;
    logic shared_duty_select;
    assign ctl = generator_control[g];
    assign shared_duty_select = ctl[`CTL_SHARED_DUTY_SELECT];

    pwm_gen #(
      .DEAD_CYCLES(DEAD_CYCLES)
    ) u_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .run(module_on),
      .own_tb(ctl[`CTL_ITB]),
      .center_aligned_enable(ctl[`CTL_CAM]),
      .immediate_duty_update(ctl[`CTL_IUE]),
      .master_period(master_period),
      .own_period(primary_phase_value[g]),
      .duty_pri(shared_duty_select ? shared_duty_value : primary_duty_value[g]),
      .duty_sec(shared_duty_select ? shared_duty_value : secondary_duty_value[g]),
      .pair_mode(pair_mode_t'(output_pair_mode[g])),
      .dead_mode(dead_mode_t'(ctl[`CTL_DTC_LO +: 2])),
      .ext_reset(ctl[`CTL_EXTERNAL_PERIOD_RESET_ENABLE] & ctl[`CTL_ITB] & cl_s2_r[g] & ~cl_s3_r[g]),
      .high_out(gen_h[g]),
      .low_out(gen_l[g]),
      .period_end(gen_end[g])
    );

    // Pending flags: only hardware events set them, a cleared enable clears them
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fault_irq_pending[g] <= 1'b0;
        current_limit_irq_pending[g] <= 1'b0;
        trigger_irq_pending[g] <= 1'b0;
      end else begin
        if (!ctl[`CTL_FLTIE])
          fault_irq_pending[g] <= 1'b0;
        else if (flt_s2_r[g] && !flt_s3_r[g])
          fault_irq_pending[g] <= 1'b1;
        if (!ctl[`CTL_CLIE])
          current_limit_irq_pending[g] <= 1'b0;
        else if (cl_s2_r[g] && !cl_s3_r[g])
          current_limit_irq_pending[g] <= 1'b1;
        if (!ctl[`CTL_TRGIE])
          trigger_irq_pending[g] <= 1'b0;
        else if (gen_end[g])
          trigger_irq_pending[g] <= 1'b1;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        high_side_output[g] <= 1'b0;
        low_side_output[g] <= 1'b0;
        controller_irq_flag[g] <= 1'b0;
      end else begin
        high_side_output[g] <= gen_h[g];
        low_side_output[g] <= gen_l[g];
        controller_irq_flag[g] <= fault_irq_pending[g] | current_limit_irq_pending[g] |
                                  trigger_irq_pending[g];
      end
    end
  end
endmodule : hires_pwm_timebase_duty

/* rtl/pwm_defines.svh */
// Offsets, field positions, reset values and limits of the PWM block.
// Included by the PWM design files only.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH
`define OFS_TB_CTRL 12'h000
`define OFS_CLK_DIV 12'h004
`define OFS_PERIOD 12'h008
`define OFS_SEVT 12'h00c
`define OFS_SDUTY 12'h010
`define OFS_MCOUNT 12'h014
`define OFS_GEN_BASE 12'h020
`define GOFS_CTRL 3'h0
`define GOFS_PDUTY 3'h1
`define GOFS_SDUTY 3'h2
`define GOFS_PHASE 3'h3
`define GOFS_MODE 3'h4
`define TB_ON_BIT 15
`define CTL_FLTST 15
`define CTL_CLST 14
`define CTL_TRGST 13
`define CTL_FLTIE 12
`define CTL_CLIE 11
`define CTL_TRGIE 10
`define CTL_ITB 9
`define CTL_SHARED_DUTY_SELECT 8
`define CTL_DTC_LO 6
`define CTL_CAM 2
`define CTL_EXTERNAL_PERIOD_RESET_ENABLE 1
`define CTL_IUE 0
`define CTL_WR_MASK 16'h1fc7
`define CTL_CFG_MASK 16'h0304
`define PERIOD_RST 16'hfff8
`define SEVT_MASK 16'hfff8
`define DUTY_MIN 16'h0009
`define DUTY_MARGIN 16'h0008
`define DIV_MAX_CODE 3'h6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/pwm_gen.sv */
// One PWM generator: time base counter, active duty copies, pair logic.
// Assumes tick is a one-cycle enable from the shared input clock divider.
`include "pwm_defines.svh"
module pwm_gen
  import pwm_pkg::*;
#(
  parameter int DEAD_CYCLES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic own_tb,
  input wire logic center_aligned_enable,
  input wire logic immediate_duty_update,
  input wire logic [15:0] master_period,
  input wire logic [15:0] own_period,
  input wire logic [15:0] duty_pri,
  input wire logic [15:0] duty_sec,
  input wire pair_mode_t pair_mode,
  input wire dead_mode_t dead_mode,
  input wire logic ext_reset,
  output logic high_out,
  output logic low_out,
  output logic period_end
);
  logic [15:0] cnt_r;
  logic down_r;
  logic phase_r;
  logic [15:0] act_p_r;
  logic [15:0] act_s_r;
  logic [7:0] dead_r;
  logic raw_h;
  logic raw_l;
  logic prev_h_r;
  logic prev_l_r;
  logic [15:0] per;
  logic center;
  logic wrap;

  function automatic logic [15:0] clamp_duty(input logic [15:0] d, input logic [15:0] p);
    if (d < `DUTY_MIN)
      clamp_duty = 16'h0000;
    else if (d > p - `DUTY_MARGIN)
      clamp_duty = p - `DUTY_MARGIN;
    else
      clamp_duty = d;
  endfunction : clamp_duty

  assign per = own_tb ? own_period : master_period;
  assign center = own_tb & center_aligned_enable;
  assign wrap = center ? (down_r && cnt_r == 16'h0000) : (cnt_r >= per - 16'h0001);

  // ****************************************
  // Time base
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= 16'h0000;
      down_r <= 1'b0;
    end else if (ext_reset) begin
      cnt_r <= 16'h0000;
      down_r <= 1'b0;
    end else if (tick) begin
      if (center) begin
        if (!down_r && cnt_r >= per)
          down_r <= 1'b1;
        else if (wrap)
          down_r <= 1'b0;
        else
          cnt_r <= down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end else begin
        cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      period_end <= 1'b0;
    else
      period_end <= run & tick & wrap;
  end

  // ****************************************
  // Active duty copies
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_p_r <= 16'h0000;
      act_s_r <= 16'h0000;
    end else if (immediate_duty_update || !run || (tick && wrap)) begin
      act_p_r <= duty_pri;
      act_s_r <= duty_sec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run)
      phase_r <= 1'b0;
    else if (tick && wrap)
      phase_r <= ~phase_r;
  end

  // ****************************************
  // Pair logic and dead time
  // ****************************************
  logic pri_on;
  logic sec_on;
  logic changed;
  logic dead_on;
  // Dead band starts in the very cycle the raw level moves
  assign changed = raw_h != prev_h_r || raw_l != prev_l_r;
  assign dead_on = changed || dead_r != 8'h00;
  assign pri_on = cnt_r < clamp_duty(act_p_r, per);
  assign sec_on = cnt_r < clamp_duty(act_s_r, per);

  always_comb begin
    case (pair_mode)
      PAIR_COMPL: begin
        raw_h = pri_on;
        raw_l = ~pri_on;
      end
      PAIR_REDUNDANT: begin
        raw_h = pri_on;
        raw_l = pri_on;
      end
      PAIR_PUSH_PULL: begin
        raw_h = pri_on & phase_r;
        raw_l = pri_on & ~phase_r;
      end
      default: begin
        raw_h = pri_on;
        raw_l = sec_on;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      dead_r <= 8'h00;
      prev_h_r <= 1'b0;
      prev_l_r <= 1'b0;
    end else begin
      prev_h_r <= raw_h;
      prev_l_r <= raw_l;
      if (changed)
        dead_r <= 8'(DEAD_CYCLES - 1);
      else if (dead_r != 8'h00)
        dead_r <= dead_r - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      high_out <= 1'b0;
      low_out <= 1'b0;
    end else if (dead_on && dead_mode == DEAD_POSITIVE) begin
      high_out <= 1'b0;
      low_out <= 1'b0;
    end else if (dead_on && dead_mode == DEAD_NEGATIVE) begin
      high_out <= 1'b1;
      low_out <= 1'b1;
    end else begin
      high_out <= raw_h;
      low_out <= raw_l;
    end
  end
endmodule : pwm_gen

/* rtl/pwm_pkg.sv */
// Types shared by the PWM design files.
// Assumes the defines header is compiled alongside.
package pwm_pkg;
  typedef enum logic [1:0] {
    PAIR_COMPL = 2'h0,
    PAIR_REDUNDANT = 2'h1,
    PAIR_PUSH_PULL = 2'h2,
    PAIR_INDEP = 2'h3
  } pair_mode_t;
  typedef enum logic [1:0] {
    DEAD_POSITIVE = 2'h0,
    DEAD_NEGATIVE = 2'h1,
    DEAD_OFF = 2'h2,
    DEAD_RSVD = 2'h3
  } dead_mode_t;
endpackage : pwm_pkg

/* testbench/hires_pwm_timebase_duty_bench.sv */
// Bench: bus tasks, random trigger and duty scenarios, verdict.
// Assumes design, checker and power stage model are compiled first.
module hires_pwm_timebase_duty_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, lfsr = 32'hecee;
  logic [3:0] sense = 4'h0;
  logic [3:0] fault_in, current_limit_in, high_side_output, low_side_output;
  logic [3:0] controller_irq_flag;
  logic special_event_trigger;
  logic [15:0] v;
  int err_count = 0;
  int comparisons = 0;
  int n, h, l, o, p, dv, d;
  always #10 aclk = ~aclk;
  hires_pwm_timebase_duty uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fault_in, .current_limit_in, .high_side_output, .low_side_output,
    .controller_irq_flag, .special_event_trigger);
  power_stage_model model (.aclk, .sense_req(sense), .fault_in, .current_limit_in);
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic limit(input int cnt);
    if (cnt >= 5000) begin
      err_count++;
      complete_run();
    end
  endtask : limit
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  function automatic int clamp_duty(input int x, input int per);
    return (x < 9) ? 0 : ((x > per - 8) ? per - 8 : x);
  endfunction : clamp_duty
  task automatic wr(input logic [11:0] a, input logic [15:0] x);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 5000);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    limit(n);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 5000);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata[15:0];
    r = s_axi_rresp;
    limit(n);
  endtask : rd
  task automatic wait_trig;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (special_event_trigger !== 1'b1 && n < 5000);
    limit(n);
  endtask : wait_trig
  // Counts high, low and overlap cycles of generator 0 over one period of 32
  task automatic settle_meas;
    repeat (40) @(posedge aclk);
    h = 0;
    l = 0;
    o = 0;
    repeat (32) begin
      @(posedge aclk);
      h += (high_side_output[0] === 1'b1);
      l += (low_side_output[0] === 1'b1);
      o += (high_side_output[0] === 1'b1 && low_side_output[0] === 1'b1);
    end
  endtask : settle_meas
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h008);
    check(v, 16'hfff8);
    rd(12'h004);
    check(v, 16'h0);
    wr(12'h00c, 16'hffff);
    rd(12'h00c);
    check(v, 16'hfff8);
    wr(12'h020, 16'he000);
    rd(12'h020);
    check(v, 16'h0);
    wr(12'h7f0, 16'h1234);
    check(r, 2'h2);
    rd(12'h7f0);
    check({r, v}, 18'h20000);
    wr(12'h008, 16'h0010);
    wr(12'h00c, 16'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_step(lfsr);
      p = (i == 0) ? 15 : lfsr[3:0];
      dv = (i == 1) ? 0 : lfsr[5:4];
      wr(12'h000, 16'h0);
      wr(12'h004, 16'(dv));
      wr(12'h000, 16'h8000 | 16'(p));
      wr(12'h004, 16'h5);
      rd(12'h004);
      check(v, 16'(dv));
      wait_trig();
      wait_trig();
      check(n, (16 * (p + 1)) << dv);
    end
    wr(12'h000, 16'h0);
    wr(12'h004, 16'h0);
    wr(12'h008, 16'h0020);
    wr(12'h020, 16'h0081);
    wr(12'h030, 16'h0003);
    wr(12'h000, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_step(lfsr);
      d = (i == 0) ? 3 : (i == 1) ? 40 : (i == 2) ? 24 : lfsr[4:0] + 4;
      wr(12'h024, 16'(d));
      wr(12'h028, {10'h0, lfsr[13:8]});
      settle_meas();
      check(h, clamp_duty(d, 32));
      check(l, clamp_duty(lfsr[13:8], 32));
    end
    wr(12'h024, 16'h0010);
    for (int m = 0; m < 3; m++) begin
      wr(12'h000, 16'h0);
      wr(12'h030, 16'h0);
      wr(12'h020, 16'h0001 | 16'(m << 6));
      wr(12'h000, 16'h8000);
      settle_meas();
      check(o, (m == 1) ? 4 : 0);
    end
    check(l, 16);
    wr(12'h000, 16'h0);
    wr(12'h010, 16'h000c);
    wr(12'h020, 16'h0181);
    wr(12'h000, 16'h8000);
    settle_meas();
    check(h, 12);
    wr(12'h020, 16'h0581);
    repeat (40) @(posedge aclk);
    rd(12'h020);
    check({controller_irq_flag[0], v}, 17'h12581);
    wr(12'h020, 16'h0181);
    rd(12'h020);
    check({controller_irq_flag[0], v}, 17'h00181);
    wr(12'h040, 16'h1800);
    sense <= 4'h2;
    repeat (10) @(posedge aclk);
    rd(12'h040);
    check({controller_irq_flag[1], v}, 17'h1d800);
    sense <= 4'h0;
    wr(12'h040, 16'h0);
    rd(12'h040);
    check({controller_irq_flag[1], v}, 17'h0);
    wr(12'h000, 16'h0);
    wr(12'h06c, 16'h0020);
    wr(12'h064, 16'h0010);
    wr(12'h060, 16'h0283);
    wr(12'h000, 16'h8000);
    repeat (8) @(posedge aclk);
    sense <= 4'h4;
    h = 0;
    repeat (32) begin
      @(posedge aclk);
      h += (high_side_output[2] === 1'b1);
    end
    check(h, 22);
    sense <= 4'h0;
    complete_run();
  end
endmodule : hires_pwm_timebase_duty_bench

/* testbench/power_stage_model.sv */
// Power stage model: fault and current-limit sense pins of each leg.
// Assumes the bench sets sense_req; pins are active high.
module power_stage_model #(
  parameter int NUM_GEN = 4
) (
  input wire logic aclk,
  input wire logic [NUM_GEN-1:0] sense_req,
  output logic [NUM_GEN-1:0] fault_in,
  output logic [NUM_GEN-1:0] current_limit_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial fault_in = {NUM_GEN{1'b0}};
  initial current_limit_in = {NUM_GEN{1'b0}};
  // Sensors report a cycle after the request
  always @(posedge aclk) begin
    fault_in <= sense_req;
    current_limit_in <= sense_req;
  end
endmodule : power_stage_model

/* testbench/pwm_props.sv */
// Checker of bus handshakes, error reads and trigger pulse width.
// Bound into the top module; sees its ports only.
module pwm_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic special_event_trigger
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during answer");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not closed");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read answer not closed");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  AST_TRIG_PULSE: assert property (special_event_trigger |=> !special_event_trigger [*8])
    else $error("trigger pulse too long");
endmodule : pwm_props
bind hires_pwm_timebase_duty pwm_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .special_event_trigger);
